// File: include/hsrb_pkg.sv
package hsrb_pkg;
	localparam int          HSRB_AW          = 8;
	localparam int          HSRB_DW          = 8;
	localparam logic [7:0]  ADDR_IDENTITY    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS      = 8'h01;
	localparam logic [7:0]  ADDR_EVENTS      = 8'h02;
	localparam logic [7:0]  ADDR_MASKS       = 8'h03;
	localparam logic [7:0]  ADDR_SYSTEM_REGULATION_TARGET      = 8'h04;
	localparam logic [7:0]  ADDR_WAKE        = 8'h05;
	localparam logic [7:0]  ADDR_TRACK       = 8'h06;
	localparam logic [7:0]  ADDR_MEAS        = 8'h07;
	localparam logic [7:0]  ADDR_CONTROL     = 8'h08;
	localparam logic [7:0]  ADDR_OPEN_V      = 8'h09;
	localparam logic [7:0]  ADDR_HARV_HIGH   = 8'h0A;
	localparam logic [7:0]  ADDR_HARV_LOW    = 8'h0B;
	localparam logic [7:0]  ADDR_SLEEP_THR   = 8'h0C;
	localparam int          ST_VALID         = 7;
	localparam int          ST_THERM         = 6;
	localparam int          ST_SYS_OV        = 5;
	localparam int          ST_HARV          = 4;
	localparam int          ST_OPEN_NEW      = 3;
	localparam int          ST_SLEEP         = 2;
	localparam int          ST_SHUTDOWN      = 1;
	localparam int          ST_WAKE          = 0;
	localparam int          EV_HARV          = 4;
	localparam int          EV_OPEN_NEW      = 3;
	localparam int          EV_VALID         = 2;
	localparam int          EV_SHUTDOWN      = 1;
	localparam int          EV_WAKE          = 0;
	localparam int          CTL_DISABLE      = 1;
	localparam logic [7:0]  EV_USED_MASK     = 8'h1F;
	localparam logic [7:0]  TRACK_USED_MASK  = 8'h1F;
	localparam logic [7:0]  WAKE_USED_MASK   = 8'hD7;
	localparam logic [7:0]  CTL_USED_MASK    = 8'h7F;
	localparam logic [7:0]  RST_ZERO         = 8'h00;
	localparam logic [7:0]  RST_SYSTEM_REGULATION_TARGET       = 8'h07;
	localparam logic [7:0]  RST_WAKE         = 8'h87;
	localparam logic [7:0]  RST_TRACK        = 8'h00;
	localparam logic [7:0]  RST_MEAS         = 8'h00;
	localparam logic [7:0]  RST_CONTROL      = 8'h00;
	localparam logic [7:0]  RST_SLEEP_THR    = 8'h00;
endpackage : hsrb_pkg

// File: src/hsrb_event_flags.sv
`timescale 1ns/10ps
module hsrb_event_flags
	import hsrb_pkg::*;
#(
	parameter int WIDTH = 5
)(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] level_i,
	input  wire logic             clear_i,
	output logic      [WIDTH-1:0] flags_o
);
	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;
	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// A change in the clearing cycle survives the clear
	always_comb
	begin
		prev_d  = level_i;
		flags_d = (clear_i ? '0 : flags_q) | (level_i ^ prev_q);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prev_q  <= '0;
			flags_q <= '0;
		end
		else
		begin
			prev_q  <= prev_d;
			flags_q <= flags_d;
		end
	end

	assign flags_o = flags_q;
endmodule : hsrb_event_flags

// File: src/hsrb_register_bank.sv
`timescale 1ns/10ps
module hsrb_register_bank
	import hsrb_pkg::*;
#(
	parameter logic [3:0] PART_ID  = 4'hA, // Arbitrary value
	parameter logic [3:0] PART_REV = 4'h5  // Arbitrary value
)(
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	input  wire logic [HSRB_AW-1:0] reg_addr_i,
	input  wire logic [HSRB_DW-1:0] reg_wdata_i,
	output logic      [HSRB_DW-1:0] reg_rdata_o,
	output logic                    reg_addr_valid_o,
	input  wire logic               open_meas_done_i,
	input  wire logic [7:0]         open_meas_value_i,
	input  wire logic               thermistor_fault_flag_i,
	input  wire logic               system_overvoltage_flag_i,
	input  wire logic               harvest_update_i,
	input  wire logic [15:0]        harvest_count_i,
	input  wire logic               sleep_active_i,
	input  wire logic               shutdown_request_pin_i,
	input  wire logic               wake_low_state_i,
	output logic      [7:0]         change_event_masks_o,
	output logic      [7:0]         system_regulation_config_o,
	output logic      [7:0]         wake_threshold_config_o,
	output logic      [7:0]         tracking_fraction_config_o,
	output logic      [7:0]         measurement_config_o,
	output logic      [7:0]         device_control_o,
	output logic      [7:0]         sleep_threshold_o,
	output logic                    shutdown_state_flag_o
);
	logic       valid_q, valid_d;
	logic       open_new_q, open_new_d;
	logic       harv_upd_q, harv_upd_d;
	logic [7:0] open_v_q, open_v_d;
	logic [7:0] masks_q, masks_d;
	logic [7:0] system_regulation_target_q, system_regulation_target_d;
	logic [7:0] wake_q, wake_d;
	logic [7:0] track_q, track_d;
	logic [7:0] meas_q, meas_d;
	logic [7:0] ctl_q, ctl_d;
	logic [7:0] slp_q, slp_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] status;
	logic [4:0] ev_level;
	logic [4:0] ev_flags;
	logic       shutdown;
	logic       ev_clear;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction : hit

	assign shutdown = shutdown_request_pin_i | ctl_q[CTL_DISABLE];

	always_comb
	begin
		status              = '0;
		status[ST_VALID]    = valid_q;
		status[ST_THERM]    = thermistor_fault_flag_i;
		status[ST_SYS_OV]   = system_overvoltage_flag_i;
		status[ST_HARV]     = harv_upd_q;
		status[ST_OPEN_NEW] = open_new_q;
		status[ST_SLEEP]    = sleep_active_i;
		status[ST_SHUTDOWN] = shutdown;
		status[ST_WAKE]     = wake_low_state_i;
	end

	assign ev_level = {status[ST_HARV], status[ST_OPEN_NEW], status[ST_VALID],
		status[ST_SHUTDOWN], status[ST_WAKE]};
	assign ev_clear = reg_rd_i && hit(reg_addr_i, ADDR_EVENTS);

	hsrb_event_flags #(
		.WIDTH     (5)
	) u_events (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.level_i   (ev_level),
		.clear_i   (ev_clear),
		.flags_o   (ev_flags)
	);

	always_comb
	begin
		reg_addr_valid_o = reg_addr_i <= ADDR_SLEEP_THR;
	end

	// Hardware sets win over same-cycle host clears
	always_comb
	begin
		valid_d    = valid_q;
		open_new_d = open_new_q;
		harv_upd_d = harv_upd_q;
		open_v_d   = open_v_q;
		masks_d    = masks_q;
		system_regulation_target_d   = system_regulation_target_q;
		wake_d     = wake_q;
		track_d    = track_q;
		meas_d     = meas_q;
		ctl_d      = ctl_q;
		slp_d      = slp_q;
		rdata_d    = rdata_q;
		if (reg_rd_i && hit(reg_addr_i, ADDR_OPEN_V))
			open_new_d = 1'b0;
		if (reg_rd_i && hit(reg_addr_i, ADDR_HARV_HIGH))
			harv_upd_d = 1'b0;
		if (reg_wr_i)
		begin
			// Identity, status, events and counts have no write path
			case (reg_addr_i)
				ADDR_MASKS:     masks_d  = reg_wdata_i & EV_USED_MASK;
				ADDR_SYSTEM_REGULATION_TARGET:    system_regulation_target_d = reg_wdata_i;
				ADDR_WAKE:      wake_d   = reg_wdata_i & WAKE_USED_MASK;
				ADDR_TRACK:     track_d  = reg_wdata_i & TRACK_USED_MASK;
				ADDR_MEAS:      meas_d   = reg_wdata_i;
				ADDR_CONTROL:   ctl_d    = reg_wdata_i & CTL_USED_MASK;
				ADDR_SLEEP_THR: slp_d    = reg_wdata_i;
				ADDR_OPEN_V:
				begin
					open_v_d = reg_wdata_i;
					valid_d  = 1'b0;
				end
				default: ;
			endcase
		end
		if (open_meas_done_i)
		begin
			valid_d    = 1'b1;
			open_new_d = 1'b1;
			open_v_d   = open_meas_value_i;
		end
		if (harvest_update_i)
			harv_upd_d = 1'b1;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				ADDR_IDENTITY:  rdata_d = {PART_ID, PART_REV};
				ADDR_STATUS:    rdata_d = status;
				ADDR_EVENTS:    rdata_d = {3'h0, ev_flags};
				ADDR_MASKS:     rdata_d = masks_q;
				ADDR_SYSTEM_REGULATION_TARGET:    rdata_d = system_regulation_target_q;
				ADDR_WAKE:      rdata_d = wake_q;
				ADDR_TRACK:     rdata_d = track_q;
				ADDR_MEAS:      rdata_d = meas_q;
				ADDR_CONTROL:   rdata_d = ctl_q;
				ADDR_OPEN_V:    rdata_d = open_v_q;
				ADDR_HARV_HIGH: rdata_d = harvest_count_i[15:8];
				ADDR_HARV_LOW:  rdata_d = harvest_count_i[7:0];
				ADDR_SLEEP_THR: rdata_d = slp_q;
				default:        rdata_d = RST_ZERO;
			endcase
		end
	end

	// Configuration survives shutdown; only a supply reset restores it
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			valid_q    <= 1'b0;
			open_new_q <= 1'b0;
			harv_upd_q <= 1'b0;
			open_v_q   <= RST_ZERO;
			masks_q    <= RST_ZERO;
			system_regulation_target_q   <= RST_SYSTEM_REGULATION_TARGET;
			wake_q     <= RST_WAKE;
			track_q    <= RST_TRACK;
			meas_q     <= RST_MEAS;
			ctl_q      <= RST_CONTROL;
			slp_q      <= RST_SLEEP_THR;
			rdata_q    <= RST_ZERO;
		end
		else
		begin
			valid_q    <= valid_d;
			open_new_q <= open_new_d;
			harv_upd_q <= harv_upd_d;
			open_v_q   <= open_v_d;
			masks_q    <= masks_d;
			system_regulation_target_q   <= system_regulation_target_d;
			wake_q     <= wake_d;
			track_q    <= track_d;
			meas_q     <= meas_d;
			ctl_q      <= ctl_d;
			slp_q      <= slp_d;
			rdata_q    <= rdata_d;
		end
	end

	assign reg_rdata_o                = rdata_q;
	assign change_event_masks_o       = masks_q;
	assign system_regulation_config_o = system_regulation_target_q;
	assign wake_threshold_config_o    = wake_q;
	assign tracking_fraction_config_o = track_q;
	assign measurement_config_o       = meas_q;
	assign device_control_o           = ctl_q;
	assign sleep_threshold_o          = slp_q;
	assign shutdown_state_flag_o      = shutdown;
endmodule : hsrb_register_bank

// File: tb/hsrb_host_model.sv
`timescale 1ns/10ps
module hsrb_host_model
	import hsrb_pkg::*;
(
	input  wire logic         sys_clk_i,
	output logic              reg_wr_o,
	output logic              reg_rd_o,
	output logic [7:0]        reg_addr_o,
	output logic [7:0]        reg_wdata_o
);
	initial
	begin
		{reg_wr_o, reg_rd_o} = 2'b00;
		{reg_addr_o, reg_wdata_o} = 16'hA55A;
	end
	// Idle lines show inverted values so stale data never looks valid
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
		@(posedge sys_clk_i);
		#1;
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
	endtask : xfer
endmodule : hsrb_host_model

// File: tb/hsrb_bank_asserts.sv
`timescale 1ns/10ps
module hsrb_bank_chk
	import hsrb_pkg::*;
(
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       open_meas_done_i,
	input wire logic       harvest_update_i,
	input wire logic       thermistor_fault_flag_i,
	input wire logic       sleep_active_i,
	input wire logic       shutdown_request_pin_i,
	input wire logic [7:0] device_control_o,
	input wire logic       shutdown_state_flag_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic rs;
	assign rs = reg_rd_i && reg_addr_i == ADDR_STATUS;
	a_shut_follow: assert property (
		shutdown_state_flag_o ==
		(shutdown_request_pin_i | device_control_o[CTL_DISABLE]))
		else $error("shutdown flag mismatch");
	a_gap_zero: assert property (
		reg_rd_i && reg_addr_i > ADDR_SLEEP_THR |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_evt_upper: assert property (
		reg_rd_i && reg_addr_i == ADDR_EVENTS |=> reg_rdata_o[7:5] == 3'h0)
		else $error("event spare bits set");
	a_live_bits: assert property (
		rs && $stable(thermistor_fault_flag_i) && $stable(sleep_active_i)
		|=> reg_rdata_o[ST_THERM] == $past(thermistor_fault_flag_i)
		&& reg_rdata_o[ST_SLEEP] == $past(sleep_active_i))
		else $error("live status bits wrong");
	a_valid_set: assert property (
		rs && $past(open_meas_done_i)
		|=> reg_rdata_o[ST_VALID] && reg_rdata_o[ST_OPEN_NEW])
		else $error("measure flags not set");
	a_harv_set: assert property (
		rs && $past(harvest_update_i) |=> reg_rdata_o[ST_HARV])
		else $error("harvest flag not set");
	// The host leaves one idle cycle between strobes
	a_harv_clear: assert property (
		reg_rd_i && reg_addr_i == ADDR_HARV_HIGH && !harvest_update_i
		##1 !harvest_update_i ##1 rs && !harvest_update_i
		|=> !reg_rdata_o[ST_HARV]) else $error("harvest flag not cleared");
	a_new_clear: assert property (
		reg_rd_i && reg_addr_i == ADDR_OPEN_V && !open_meas_done_i
		##1 !open_meas_done_i ##1 rs && !open_meas_done_i
		|=> !reg_rdata_o[ST_OPEN_NEW]) else $error("new flag not cleared");
	a_valid_clear: assert property (
		reg_wr_i && reg_addr_i == ADDR_OPEN_V && !open_meas_done_i
		##1 !open_meas_done_i ##1 rs && !open_meas_done_i
		|=> !reg_rdata_o[ST_VALID]) else $error("valid flag not cleared");
	c_meas: cover property (open_meas_done_i ##1 rs);
	c_harv: cover property (reg_rd_i && reg_addr_i == ADDR_HARV_HIGH);
	c_shut: cover property ($rose(shutdown_state_flag_o));
endmodule : hsrb_bank_chk
bind hsrb_register_bank hsrb_bank_chk hsrb_bank_chk_i (.*);

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
	import hsrb_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        reg_wr_i, reg_rd_i, reg_addr_valid_o, shutdown_state_flag_o;
	logic        open_meas_done_i, harvest_update_i, thermistor_fault_flag_i;
	logic        system_overvoltage_flag_i, sleep_active_i, wake_low_state_i;
	logic        shutdown_request_pin_i, pend = 1'b0, in_map;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, device_control_o, r;
	logic [7:0]  open_meas_value_i, exp_q[$];
	logic [15:0] harvest_count_i;
	int          fails = 0, num_checks = 0, cyc = 0, seed = 32'h78B7E6E6;
	always #5 sys_clk_i = ~sys_clk_i;
	hsrb_register_bank #(
		.PART_ID                    (4'hA),
		.PART_REV                   (4'h5)
	) hsrb_register_bank_i (
		.sys_clk_i                  (sys_clk_i),
		.rst_n_i                    (rst_n_i),
		.reg_wr_i                   (reg_wr_i),
		.reg_rd_i                   (reg_rd_i),
		.reg_addr_i                 (reg_addr_i),
		.reg_wdata_i                (reg_wdata_i),
		.reg_rdata_o                (reg_rdata_o),
		.reg_addr_valid_o           (reg_addr_valid_o),
		.open_meas_done_i           (open_meas_done_i),
		.open_meas_value_i          (open_meas_value_i),
		.thermistor_fault_flag_i    (thermistor_fault_flag_i),
		.system_overvoltage_flag_i  (system_overvoltage_flag_i),
		.harvest_update_i           (harvest_update_i),
		.harvest_count_i            (harvest_count_i),
		.sleep_active_i             (sleep_active_i),
		.shutdown_request_pin_i     (shutdown_request_pin_i),
		.wake_low_state_i           (wake_low_state_i),
		.change_event_masks_o       (),
		.system_regulation_config_o (),
		.wake_threshold_config_o    (),
		.tracking_fraction_config_o (),
		.measurement_config_o       (),
		.device_control_o           (device_control_o),
		.sleep_threshold_o          (),
		.shutdown_state_flag_o      (shutdown_state_flag_o)
	);
	hsrb_host_model hsrb_host_model_i (.sys_clk_i(sys_clk_i),
		.reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i));
	task finish_test;
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		hsrb_host_model_i.xfer(1'b0, a, 8'h00);
	endtask : rd
	task wr(input logic [7:0] a, input logic [7:0] d);
		hsrb_host_model_i.xfer(1'b1, a, d);
	endtask : wr
	task tick;
		@(posedge sys_clk_i);
		#1;
	endtask : tick
	// Shutdown bit is the pin ORed with the disable bit of the control value last written, held in r
	function logic [7:0] st(input logic v, input logic h, input logic n);
		return {v, thermistor_fault_flag_i, system_overvoltage_flag_i, h, n,
			sleep_active_i, shutdown_request_pin_i | r[CTL_DISABLE],
			wake_low_state_i};
	endfunction : st
	always @(negedge sys_clk_i)
	begin
		// Only mapped addresses may be flagged valid on reg_addr_valid_o
		in_map = reg_addr_i <= ADDR_SLEEP_THR;
		if (reg_rd_i || reg_wr_i)
			chk({7'h00, reg_addr_valid_o}, {7'h00, in_map});
		if (pend && exp_q.size() > 0)
			chk(reg_rdata_o, exp_q.pop_front());
		pend = reg_rd_i;
	end
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			finish_test();
		end
	end
	initial
	begin
		{open_meas_done_i, harvest_update_i, thermistor_fault_flag_i} = '0;
		{system_overvoltage_flag_i, sleep_active_i, wake_low_state_i} = '0;
		{shutdown_request_pin_i, open_meas_value_i, harvest_count_i} = '0;
		r = 8'h00;
		repeat (20) @(posedge sys_clk_i);
		#1;
		rst_n_i = 1'b1;
		rd(ADDR_STATUS, 8'h00);
		rd(ADDR_IDENTITY, 8'hA5);
		wr(ADDR_IDENTITY, 8'h3C);
		rd(ADDR_IDENTITY, 8'hA5);
		rd(ADDR_EVENTS, 8'h00);
		tick;
		{harvest_update_i, harvest_count_i} = {1'b1, 16'($random(seed))};
		// Status read lands on the edge right after the update pulse
		fork
			rd(ADDR_STATUS, st(0, 1, 0));
			begin
				tick;
				harvest_update_i = 1'b0;
			end
		join
		rd(ADDR_EVENTS, 8'h10);
		rd(ADDR_EVENTS, 8'h00);
		rd(ADDR_HARV_LOW, harvest_count_i[7:0]);
		rd(ADDR_STATUS, st(0, 1, 0));
		rd(ADDR_HARV_HIGH, harvest_count_i[15:8]);
		rd(ADDR_STATUS, st(0, 0, 0));
		tick;
		{open_meas_done_i, open_meas_value_i} = {1'b1, 8'($random(seed))};
		fork
			rd(ADDR_STATUS, st(1, 0, 1));
			begin
				tick;
				open_meas_done_i = 1'b0;
			end
		join
		rd(ADDR_OPEN_V, open_meas_value_i);
		rd(ADDR_STATUS, st(1, 0, 0));
		wr(ADDR_OPEN_V, ~open_meas_value_i);
		rd(ADDR_STATUS, st(0, 0, 0));
		rd(ADDR_OPEN_V, ~open_meas_value_i);
		// Harvest fall, valid and new rise and fall, all since last clear
		rd(ADDR_EVENTS, 8'h1C);
		repeat (8)
		begin
			r = 8'($random(seed));
			{thermistor_fault_flag_i, system_overvoltage_flag_i} = r[4:3];
			{sleep_active_i, shutdown_request_pin_i, wake_low_state_i} = r[7:5];
			wr(ADDR_CONTROL, r);
			rd(ADDR_CONTROL, r & CTL_USED_MASK);
			rd(ADDR_STATUS, st(0, 0, 0));
			rd(ADDR_STATUS, st(0, 0, 0));
		end
		wr(ADDR_MASKS, 8'hFF);
		rd(ADDR_MASKS, EV_USED_MASK);
		for (int a = 13; a < 256; a += 61)
			rd(8'(a), 8'h00);
		repeat (4) tick;
		finish_test();
	end
endmodule : tb
